//--- core/ptp_cfg_pkg.sv
`default_nettype none
package ptp_cfg_pkg;
  // ****************************************************
  // widths and types
  // ****************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 16;
  typedef logic [ADDR_W-1:0] addr_t;
  typedef logic [DATA_W-1:0] word_t;
  typedef logic [3:0] msg_code_t;
  typedef logic [2:0] port_mask_t;
  typedef logic [1:0] port_id_t;
  typedef logic [1:0] encap_t;
  typedef logic [1:0] byte_en_t;

  // ****************************************************
  // register map
  // ****************************************************
  localparam addr_t CFG1_ADDR = 12'h620;
  localparam addr_t CFG2_ADDR = 12'h622;
  localparam word_t CFG1_RESET = 16'h0059;
  localparam word_t CFG2_RESET = 16'h0400;
  localparam word_t CFG1_WMASK = 16'h00ff;
  localparam word_t CFG2_WMASK = 16'h1f80;
  localparam word_t LOW_BYTE = 16'h00ff;
  localparam word_t HIGH_BYTE = 16'hff00;
  localparam word_t ZERO_WORD = 16'h0000;

  // first register fields
  localparam int GPTP_BIT = 7;
  localparam int PTP_EN_BIT = 6;
  localparam int ETH_DET_BIT = 5;
  localparam int IPV4_DET_BIT = 4;
  localparam int IPV6_DET_BIT = 3;
  localparam int P2P_BIT = 2;
  localparam int MASTER_BIT = 1;
  localparam int ONE_STEP_BIT = 0;
  // second register fields
  localparam int UCAST_BIT = 12;
  localparam int ALT_MASTER_BIT = 11;
  localparam int PRIO_ALL_BIT = 10;
  localparam int FUP_CHK_BIT = 9;
  localparam int DRESP_CHK_BIT = 8;
  localparam int PDRESP_CHK_BIT = 7;

  // ****************************************************
  // packet classification codes
  // ****************************************************
  localparam logic [15:0] UDP_EVENT_PORT = 16'h013f;
  localparam logic [15:0] UDP_GENERAL_PORT = 16'h0140;
  localparam msg_code_t MSG_SYNC = 4'h0;
  localparam msg_code_t MSG_DREQ = 4'h1;
  localparam msg_code_t MSG_PDRESP = 4'h3;
  localparam msg_code_t MSG_FUP = 4'h8;
  localparam msg_code_t MSG_DRESP = 4'h9;
  localparam msg_code_t MSG_PDRESP_FUP = 4'ha;
  localparam int MSG_GENERAL_BIT = 3;
  localparam encap_t ENC_ETH = 2'h1;
  localparam encap_t ENC_IPV4 = 2'h2;
  localparam encap_t ENC_IPV6 = 2'h3;
  localparam port_id_t SRC_P1 = 2'h1;
  localparam port_id_t SRC_P2 = 2'h2;
  localparam port_id_t SRC_P3 = 2'h3;
  localparam port_mask_t MASK_NONE = 3'h0;
  localparam port_mask_t MASK_P1 = 3'h1;
  localparam port_mask_t MASK_P2 = 3'h2;
  localparam port_mask_t MASK_P3 = 3'h4;
  localparam int P3_IDX = 2;
endpackage
`default_nettype wire

//--- core/ptp_msg_cfg.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - general timing profile bit sends every multicast timing packet from a line port to port 3.
// - timing protocol mode bit enables timing handling; reset value one.
// - ethernet encapsulation detected only while its enable bit is set.
// - ipv4/udp encapsulation detected only while its enable bit is set.
// - ipv6/udp encapsulation detected only while its enable bit is set.
// - transparent clock is peer-to-peer when set, end-to-end when clear.
// - port 3 acts as master when set, slave when clear.
// - one-step operation when set (reset), two-step when clear.
// - unicast enabled: udp 319/320 to non-reserved address is unicast timing.
// - unicast timing traffic is forwarded by ordinary table lookup.
// - unicast disabled: only multicast timing packets are recognised.
// - alternate master: same-domain master messages cross to other line port.
// - no alternate master: sync never crosses between line ports.
// - no alternate master: same-domain delay request from a master kept off port 3.
// - priority bit puts all timing messages in top queue, else events only.
// - follow-up checking associates follow-up with sync, port 3 only.
// - delay response checking: match to port 3, else to line port.
// - peer delay response checking: only matches reach port 3.
module ptp_msg_cfg (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire ptp_cfg_pkg::addr_t i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire ptp_cfg_pkg::byte_en_t i_be,
  input wire ptp_cfg_pkg::word_t i_wdata,
  output var ptp_cfg_pkg::word_t o_rdata,
  output logic o_rvalid,
  input wire logic i_pkt_valid,
  input wire ptp_cfg_pkg::encap_t i_pkt_encap,
  input wire logic i_pkt_reserved_addr,
  input wire logic [15:0] i_pkt_udp_dport,
  input wire ptp_cfg_pkg::msg_code_t i_pkt_msg_type,
  input wire ptp_cfg_pkg::port_id_t i_pkt_src_port,
  input wire logic i_pkt_same_domain,
  input wire logic i_pkt_from_master,
  input wire logic i_pkt_assoc_match,
  output logic o_dec_valid,
  output logic o_is_timing,
  output logic o_use_table,
  output var ptp_cfg_pkg::port_mask_t o_fwd_mask,
  output logic o_drop,
  output logic o_hi_queue,
  output logic o_ptp_enable,
  output logic o_tc_p2p,
  output logic o_port3_master,
  output logic o_one_step
);
  import ptp_cfg_pkg::*;

  word_t cfg1_reg;
  word_t cfg2_reg;
  word_t rdata_reg;
  logic rvalid_reg;
  word_t be_mask;
  logic sel1;
  logic sel2;

  // ****************************************************
  // host register access
  // ****************************************************
  assign be_mask = (i_be[0] ? LOW_BYTE : ZERO_WORD) |
                   (i_be[1] ? HIGH_BYTE : ZERO_WORD);
  // halfword access: address bit 0 is ignored
  assign sel1 = (i_addr[ADDR_W-1:1] == CFG1_ADDR[ADDR_W-1:1]);
  assign sel2 = (i_addr[ADDR_W-1:1] == CFG2_ADDR[ADDR_W-1:1]);

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg1_reg <= CFG1_RESET;
    end else if (i_wr && sel1) begin
      cfg1_reg <= ((cfg1_reg & ~be_mask) | (i_wdata & be_mask))
                  & CFG1_WMASK;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      cfg2_reg <= CFG2_RESET;
    end else if (i_wr && sel2) begin
      cfg2_reg <= ((cfg2_reg & ~be_mask) | (i_wdata & be_mask))
                  & CFG2_WMASK;
    end
  end

  // unmapped reads answer zero
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rdata_reg <= ZERO_WORD;
      rvalid_reg <= 1'b0;
    end else begin
      rvalid_reg <= i_rd;
      if (i_rd) begin
        rdata_reg <= sel1 ? cfg1_reg : (sel2 ? cfg2_reg : ZERO_WORD);
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_rvalid = rvalid_reg;
  assign o_ptp_enable = cfg1_reg[PTP_EN_BIT];
  assign o_tc_p2p = cfg1_reg[P2P_BIT];
  assign o_port3_master = cfg1_reg[MASTER_BIT];
  assign o_one_step = cfg1_reg[ONE_STEP_BIT];

  // ****************************************************
  // per-packet forwarding decision
  // ****************************************************
  logic enc_ok;
  logic ucast_c;
  logic timing_c;
  logic line_path;
  logic same_c;
  port_mask_t other_line;
  port_mask_t mask_c;

  always_comb begin
    enc_ok = 1'b0;
    if (i_pkt_encap == ENC_ETH) begin
      enc_ok = cfg1_reg[ETH_DET_BIT];
    end else if (i_pkt_encap == ENC_IPV4) begin
      enc_ok = cfg1_reg[IPV4_DET_BIT];
    end else if (i_pkt_encap == ENC_IPV6) begin
      enc_ok = cfg1_reg[IPV6_DET_BIT];
    end
  end

  // only ip frames carry a udp port to test
  assign ucast_c = cfg2_reg[UCAST_BIT] && !i_pkt_reserved_addr &&
                   (i_pkt_encap == ENC_IPV4 || i_pkt_encap == ENC_IPV6) &&
                   (i_pkt_udp_dport == UDP_EVENT_PORT ||
                    i_pkt_udp_dport == UDP_GENERAL_PORT);
  assign timing_c = cfg1_reg[PTP_EN_BIT] && enc_ok &&
                    (i_pkt_reserved_addr || ucast_c);
  assign line_path = timing_c && !ucast_c && i_pkt_src_port != SRC_P3;
  assign same_c = i_pkt_same_domain && i_pkt_from_master;
  assign other_line = (i_pkt_src_port == SRC_P1) ? MASK_P2 : MASK_P1;

  always_comb begin
    mask_c = MASK_NONE;
    if (!timing_c || ucast_c) begin
      mask_c = MASK_NONE;
    end else if (i_pkt_src_port == SRC_P3) begin
      mask_c = MASK_P1 | MASK_P2;
    end else if (cfg1_reg[GPTP_BIT]) begin
      mask_c = MASK_P3;
    end else begin
      mask_c = MASK_P3;
      unique case (i_pkt_msg_type)
        MSG_SYNC: begin
          // sync crosses only with alternate master
          if (cfg2_reg[ALT_MASTER_BIT] && same_c) begin
            mask_c = MASK_P3 | other_line;
          end
        end
        MSG_FUP: begin
          if (cfg2_reg[ALT_MASTER_BIT] && same_c) begin
            mask_c = MASK_P3 | other_line;
          end
          if (cfg2_reg[FUP_CHK_BIT] && !i_pkt_assoc_match) begin
            mask_c[P3_IDX] = 1'b0;
          end
        end
        MSG_DREQ: begin
          if (cfg2_reg[ALT_MASTER_BIT]) begin
            if (same_c) begin
              mask_c = MASK_P3 | other_line;
            end
          end else if (same_c) begin
            // dropped outright rather than only kept off port 3
            mask_c = MASK_NONE;
          end else if (!i_pkt_same_domain) begin
            mask_c = other_line;
          end
        end
        MSG_DRESP: begin
          if (cfg2_reg[ALT_MASTER_BIT] && same_c) begin
            mask_c = MASK_P3 | other_line;
          end
          if (cfg2_reg[DRESP_CHK_BIT]) begin
            mask_c = i_pkt_assoc_match ? MASK_P3 : other_line;
          end
        end
        MSG_PDRESP, MSG_PDRESP_FUP: begin
          if (cfg2_reg[PDRESP_CHK_BIT] && !i_pkt_assoc_match) begin
            mask_c = MASK_NONE;
          end
        end
        default: begin
          mask_c = MASK_P3;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_dec_valid <= 1'b0;
      o_is_timing <= 1'b0;
      o_use_table <= 1'b0;
      o_fwd_mask <= MASK_NONE;
      o_drop <= 1'b0;
      o_hi_queue <= 1'b0;
    end else begin
      o_dec_valid <= i_pkt_valid;
      if (i_pkt_valid) begin
        o_is_timing <= timing_c;
        o_use_table <= !timing_c || ucast_c;
        o_fwd_mask <= mask_c;
        o_drop <= timing_c && !ucast_c && mask_c == MASK_NONE;
        // event messages carry a clear top type bit
        o_hi_queue <= timing_c && (cfg2_reg[PRIO_ALL_BIT] ||
                      !i_pkt_msg_type[MSG_GENERAL_BIT]);
      end
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  gptp_to_host_a: assert property (
    i_pkt_valid && line_path && cfg1_reg[GPTP_BIT]
    |=> o_fwd_mask == MASK_P3 && o_is_timing)
    else $error("general profile packet not sent to port 3 alone");

  mode_off_a: assert property (
    i_pkt_valid && !cfg1_reg[PTP_EN_BIT] |=> o_dec_valid && !o_is_timing)
    else $error("timing packet seen while mode disabled");

  eth_gate_a: assert property (
    i_pkt_valid && i_pkt_encap == ENC_ETH && !cfg1_reg[ETH_DET_BIT]
    |=> !o_is_timing)
    else $error("ethernet timing packet detected while gated off");

  ip_gate_a: assert property (
    i_pkt_valid && i_pkt_encap == ENC_IPV4 && !cfg1_reg[IPV4_DET_BIT]
    |=> !o_is_timing)
    else $error("ipv4 timing packet detected while gated off");

  ip6_gate_a: assert property (
    i_pkt_valid && i_pkt_encap == ENC_IPV6 && !cfg1_reg[IPV6_DET_BIT]
    |=> !o_is_timing)
    else $error("ipv6 timing packet detected while gated off");

  tc_mode_a: assert property (
    i_wr && sel1 && i_be[0] |=> o_tc_p2p == $past(i_wdata[P2P_BIT]))
    else $error("transparent clock mode did not follow write");

  host_role_a: assert property (
    i_wr && sel1 && i_be[0] |=> o_port3_master == $past(i_wdata[MASTER_BIT]))
    else $error("port 3 role did not follow write");

  step_mode_a: assert property (
    i_wr && sel1 && i_be[0] |=> o_one_step == $past(i_wdata[ONE_STEP_BIT]))
    else $error("step mode did not follow write");

  ucast_table_a: assert property (
    i_pkt_valid && cfg1_reg[PTP_EN_BIT] && enc_ok && ucast_c
    |=> o_is_timing && o_use_table && !o_drop)
    else $error("unicast timing packet not sent to table lookup");

  mcast_only_a: assert property (
    i_pkt_valid && !cfg2_reg[UCAST_BIT] && !i_pkt_reserved_addr
    |=> !o_is_timing && o_use_table)
    else $error("non-multicast packet recognised with unicast off");

  alt_cross_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] && same_c &&
    cfg2_reg[ALT_MASTER_BIT] && i_pkt_msg_type == MSG_SYNC
    |=> (o_fwd_mask & (MASK_P1 | MASK_P2)) == $past(other_line))
    else $error("alternate master sync not crossed");

  sync_block_a: assert property (
    i_pkt_valid && line_path && !cfg2_reg[ALT_MASTER_BIT] &&
    i_pkt_msg_type == MSG_SYNC
    |=> (o_fwd_mask & (MASK_P1 | MASK_P2)) == MASK_NONE)
    else $error("sync crossed line ports without alternate master");

  dreq_discard_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] && same_c &&
    !cfg2_reg[ALT_MASTER_BIT] && i_pkt_msg_type == MSG_DREQ
    |=> o_fwd_mask == MASK_NONE && o_drop)
    else $error("same domain delay request reached port 3");

  dreq_other_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] && !i_pkt_same_domain &&
    !cfg2_reg[ALT_MASTER_BIT] && i_pkt_msg_type == MSG_DREQ
    |=> o_fwd_mask == $past(other_line))
    else $error("other domain delay request not sent to opposite port");

  queue_sel_a: assert property (
    i_pkt_valid && !cfg2_reg[PRIO_ALL_BIT] &&
    i_pkt_msg_type[MSG_GENERAL_BIT] |=> !o_hi_queue)
    else $error("general message in top queue");

  event_queue_a: assert property (
    i_pkt_valid && cfg1_reg[PTP_EN_BIT] && enc_ok && i_pkt_reserved_addr &&
    !i_pkt_msg_type[MSG_GENERAL_BIT] |=> o_hi_queue)
    else $error("timing event message not in top queue");

  fup_assoc_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] &&
    cfg2_reg[FUP_CHK_BIT] && !i_pkt_assoc_match && i_pkt_msg_type == MSG_FUP
    |=> !o_fwd_mask[P3_IDX])
    else $error("unassociated follow-up reached port 3");

  dresp_assoc_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] &&
    cfg2_reg[DRESP_CHK_BIT] && i_pkt_msg_type == MSG_DRESP
    |=> o_fwd_mask == ($past(i_pkt_assoc_match) ? MASK_P3 : $past(other_line)))
    else $error("delay response misrouted");

  pdresp_assoc_a: assert property (
    i_pkt_valid && line_path && !cfg1_reg[GPTP_BIT] &&
    cfg2_reg[PDRESP_CHK_BIT] && !i_pkt_assoc_match &&
    i_pkt_msg_type == MSG_PDRESP |=> o_drop)
    else $error("unmatched peer delay response not dropped");

  reserved_zero_a: assert property (
    i_rd && (sel1 || sel2) |=> o_rvalid &&
    (o_rdata & ~($past(sel1) ? CFG1_WMASK : CFG2_WMASK)) == ZERO_WORD)
    else $error("reserved bits read nonzero");

  // ****************************************************
  // cover points
  // ****************************************************
  cover_ucast_c: cover property (i_pkt_valid && ucast_c ##1 o_use_table);
  cover_alt_c: cover property (
    i_pkt_valid && line_path && cfg2_reg[ALT_MASTER_BIT] && same_c);
  cover_drop_c: cover property (i_pkt_valid ##1 o_drop);
  cover_gptp_c: cover property (
    i_pkt_valid && line_path && cfg1_reg[GPTP_BIT]);
  cover_rw_c: cover property (i_wr && sel2 ##2 i_rd && sel2 ##1 o_rvalid);
endmodule
`default_nettype wire

//--- verif/ptp_msg_cfg_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_msg_cfg_tb;
  import ptp_cfg_pkg::*;
  // ****************************************************
  // stimulus table and bench state
  // ****************************************************
  typedef struct {
    word_t c1;
    word_t c2;
    encap_t enc;
    logic rsv;
    logic [15:0] dp;
    msg_code_t mt;
    port_id_t src;
    logic [2:0] sml;
    logic [3:0] ef;
    port_mask_t msk;
  } row_t;
  localparam int LIMIT = 2000;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  addr_t i_addr = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  byte_en_t i_be = '0;
  word_t i_wdata = '0;
  logic i_pkt_valid = 1'b0;
  encap_t i_pkt_encap = '0;
  logic i_pkt_reserved_addr = 1'b0;
  logic [15:0] i_pkt_udp_dport = '0;
  msg_code_t i_pkt_msg_type = '0;
  port_id_t i_pkt_src_port = '0;
  logic i_pkt_same_domain = 1'b0;
  logic i_pkt_from_master = 1'b0;
  logic i_pkt_assoc_match = 1'b0;
  word_t o_rdata;
  logic o_rvalid, o_dec_valid, o_is_timing, o_use_table, o_drop;
  logic o_hi_queue, o_ptp_enable, o_tc_p2p, o_port3_master, o_one_step;
  port_mask_t o_fwd_mask;
  int fails = 0;
  int num_checks = 0;
  int cycles = 0;
  // flags: same domain, from master, assoc match | timing, table, drop, hi
  row_t rows [24] = '{
    '{16'h0059, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b1001, MASK_P3},
    '{16'h0019, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h0049, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h0059, 16'h0400, ENC_ETH, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h0079, 16'h0400, ENC_ETH, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b1001, MASK_P3},
    '{16'h0051, 16'h0400, ENC_IPV6, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h0059, 16'h0400, ENC_IPV6, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b1001, MASK_P3},
    '{16'h0059, 16'h1400, ENC_IPV4, 1'b0, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b1101, MASK_NONE},
    '{16'h0059, 16'h1400, ENC_IPV6, 1'b0, 16'h0140, MSG_FUP, SRC_P1,
      3'b110, 4'b1101, MASK_NONE},
    '{16'h0059, 16'h1400, ENC_IPV4, 1'b0, 16'h0141, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h0059, 16'h0400, ENC_IPV4, 1'b0, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b0100, MASK_NONE},
    '{16'h00d9, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_DREQ, SRC_P1,
      3'b110, 4'b1001, MASK_P3},
    '{16'h0059, 16'h0c00, ENC_IPV4, 1'b1, 16'h013f, MSG_SYNC, SRC_P1,
      3'b110, 4'b1001, 3'h6},
    '{16'h0059, 16'h0c00, ENC_IPV4, 1'b1, 16'h013f, MSG_DRESP, SRC_P2,
      3'b110, 4'b1001, 3'h5},
    '{16'h0059, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_SYNC, SRC_P2,
      3'b110, 4'b1001, MASK_P3},
    '{16'h0059, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_DREQ, SRC_P1,
      3'b110, 4'b1011, MASK_NONE},
    '{16'h0059, 16'h0400, ENC_IPV4, 1'b1, 16'h013f, MSG_DREQ, SRC_P2,
      3'b010, 4'b1001, MASK_P1},
    '{16'h0059, 16'h0000, ENC_IPV4, 1'b1, 16'h013f, MSG_FUP, SRC_P1,
      3'b110, 4'b1000, MASK_P3},
    '{16'h0059, 16'h0600, ENC_IPV4, 1'b1, 16'h013f, MSG_FUP, SRC_P1,
      3'b110, 4'b1011, MASK_NONE},
    '{16'h0059, 16'h0600, ENC_IPV4, 1'b1, 16'h013f, MSG_FUP, SRC_P1,
      3'b111, 4'b1001, MASK_P3},
    '{16'h0059, 16'h0500, ENC_IPV4, 1'b1, 16'h013f, MSG_DRESP, SRC_P1,
      3'b111, 4'b1001, MASK_P3},
    '{16'h0059, 16'h0500, ENC_IPV4, 1'b1, 16'h013f, MSG_DRESP, SRC_P1,
      3'b110, 4'b1001, MASK_P2},
    '{16'h0059, 16'h0480, ENC_IPV4, 1'b1, 16'h013f, MSG_PDRESP, SRC_P2,
      3'b110, 4'b1011, MASK_NONE},
    '{16'h0059, 16'h0480, ENC_IPV4, 1'b1, 16'h013f, MSG_PDRESP_FUP, SRC_P1,
      3'b111, 4'b1001, MASK_P3}
  };

  ptp_msg_cfg ptp_msg_cfg_inst (.i_clk(i_clk), .i_reset(i_reset),
    .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_be(i_be),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .o_rvalid(o_rvalid),
    .i_pkt_valid(i_pkt_valid), .i_pkt_encap(i_pkt_encap),
    .i_pkt_reserved_addr(i_pkt_reserved_addr),
    .i_pkt_udp_dport(i_pkt_udp_dport), .i_pkt_msg_type(i_pkt_msg_type),
    .i_pkt_src_port(i_pkt_src_port), .i_pkt_same_domain(i_pkt_same_domain),
    .i_pkt_from_master(i_pkt_from_master),
    .i_pkt_assoc_match(i_pkt_assoc_match), .o_dec_valid(o_dec_valid),
    .o_is_timing(o_is_timing), .o_use_table(o_use_table),
    .o_fwd_mask(o_fwd_mask), .o_drop(o_drop), .o_hi_queue(o_hi_queue),
    .o_ptp_enable(o_ptp_enable), .o_tc_p2p(o_tc_p2p),
    .o_port3_master(o_port3_master), .o_one_step(o_one_step));

  always #2 i_clk = ~i_clk;

  // ****************************************************
  // bus and check tasks
  // ****************************************************
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // a stuck bench must still reach the verdict
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fails++;
      close_out();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus tasks start and end 1 ns after a rising edge
  task automatic wr(input addr_t a, input word_t d, input byte_en_t b);
    i_addr = a;
    i_wdata = d;
    i_be = b;
    i_wr = 1'b1;
    @(posedge i_clk);
    #1;
    i_wr = 1'b0;
    // idle edge so the next strobe is not set in this time step
    @(posedge i_clk);
    #1;
  endtask

  task automatic rd(input addr_t a, input word_t exp);
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk);
    #1;
    i_rd = 1'b0;
    chk({15'h0000, o_rvalid}, 16'h0001);
    chk(o_rdata, exp);
    @(posedge i_clk);
    #1;
  endtask

  task automatic cfg_out(input logic [3:0] exp);
    chk({12'h000, o_ptp_enable, o_tc_p2p, o_port3_master, o_one_step},
        {12'h000, exp});
  endtask

  task automatic load(input row_t r);
    i_pkt_encap = r.enc;
    i_pkt_reserved_addr = r.rsv;
    i_pkt_udp_dport = r.dp;
    i_pkt_msg_type = r.mt;
    i_pkt_src_port = r.src;
    {i_pkt_same_domain, i_pkt_from_master, i_pkt_assoc_match} = r.sml;
  endtask

  task automatic dec_out(input row_t r);
    chk({15'h0000, o_dec_valid}, 16'h0001);
    chk({8'h00, o_is_timing, o_use_table, o_drop, o_hi_queue, 1'b0,
        o_fwd_mask}, {8'h00, r.ef, 1'b0, r.msk});
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (6) @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    cfg_out(4'b1001);
    rd(CFG1_ADDR, 16'h0059);
    rd(CFG2_ADDR, 16'h0400);
    $display("reset test done");
    wr(CFG1_ADDR, 16'hffff, 2'h3);
    cfg_out(4'b1111);
    rd(CFG1_ADDR, 16'h00ff);
    wr(CFG2_ADDR, 16'hffff, 2'h3);
    rd(CFG2_ADDR, 16'h1f80);
    wr(12'h621, 16'h0000, 2'h2);
    wr(CFG1_ADDR, 16'h0000, 2'h0);
    rd(12'h621, 16'h00ff);
    wr(12'h624, 16'h0000, 2'h3);
    rd(12'h624, 16'h0000);
    rd(CFG2_ADDR, 16'h1f80);
    wr(CFG1_ADDR, 16'h0000, 2'h1);
    cfg_out(4'b0000);
    // reset is asynchronous, so defaults show before any edge
    i_reset = 1'b1;
    #1;
    cfg_out(4'b1001);
    @(posedge i_clk);
    #1;
    i_reset = 1'b0;
    rd(CFG2_ADDR, 16'h0400);
    $display("register access test done");
    foreach (rows[i]) begin
      wr(CFG1_ADDR, rows[i].c1, 2'h3);
      wr(CFG2_ADDR, rows[i].c2, 2'h3);
      cfg_out({rows[i].c1[6], rows[i].c1[2:0]});
      load(rows[i]);
      i_pkt_valid = 1'b1;
      @(posedge i_clk);
      #1;
      i_pkt_valid = 1'b0;
      dec_out(rows[i]);
      $display("row %0d done", i);
    end
    // back to back: a dropped request then a forwarded sync
    wr(CFG2_ADDR, 16'h0400, 2'h3);
    load(rows[15]);
    i_pkt_valid = 1'b1;
    @(posedge i_clk);
    #1;
    load(rows[0]);
    dec_out(rows[15]);
    @(posedge i_clk);
    #1;
    i_pkt_valid = 1'b0;
    dec_out(rows[0]);
    $display("back to back test done");
    close_out();
  end
endmodule
`default_nettype wire
